// >>> rtl/sadc_pkg.sv
package sadc_pkg;

  // Result word and serial frame
  localparam int RES_BITS = 12;
  localparam int CNT_W    = 7;
  localparam int FIFO_DEPTH = 16;

  // Falling-edge counts within one frame
  localparam logic [CNT_W-1:0] FALLS_TO_CONVERT = 7'h0f;
  localparam logic [CNT_W-1:0] FALLS_FIRST_CAL  = 7'h18;
  localparam logic [CNT_W-1:0] FALLS_RUN_CAL    = 7'h40;
  localparam logic [CNT_W-1:0] LAST_BIT_FALL    = 7'h0c;
  localparam logic [CNT_W-1:0] FIRST_BIT_FALL   = 7'h01;

  // Ideal transfer codes
  localparam logic [RES_BITS-1:0] negative_full_scale_code = 12'h800;
  localparam logic [RES_BITS-1:0] mid_scale_code           = 12'h000;
  localparam logic [RES_BITS-1:0] positive_full_scale_code = 12'h7ff;
  localparam logic [RES_BITS-1:0] INVALID_CODE             = 12'hfff;
  localparam logic [RES_BITS-1:0] FULL_INPUT               = 12'hfff;
  localparam logic [RES_BITS-1:0] ZERO_INPUT               = 12'h000;

  // Timing at the reference clock
  localparam int REF_PERIOD_NS = 100;
  localparam int CAL_TIME_NS   = 2000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int CAL_CNT_W     = 5;
  localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

  typedef enum logic [1:0] {
    acquire_state    = 2'h0,
    convert_state    = 2'h1,
    offset_cal_state = 2'h3
  } sadc_state_type;

  // Difference of the held levels, halved into the output step size
  function automatic logic [RES_BITS-1:0] to_code(input logic [RES_BITS-1:0] pos,
                                                 input logic [RES_BITS-1:0] neg);
    logic [RES_BITS:0] diff;
    diff = {1'b0, pos} - {1'b0, neg};
    return diff[RES_BITS:1];
  endfunction

endpackage

// >>> rtl/sadc_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sadc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             empty;
  logic             full;
  logic             push;
  logic             load;

  assign empty = (wr_q == rd_q);
  assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign push  = in_valid_in && !full;
  // Head register refills when empty or being taken
  assign load  = !empty && (!out_valid_q || out_ready_in);

  assign in_ready_out  = !full;
  assign out_valid_out = out_valid_q;
  assign out_data_out  = out_data_q;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= load ? rd_q + 1'b1 : rd_q;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (load) begin
      out_valid_q <= 1'b1;
      out_data_q  <= mem_q[rd_q[AW-1:0]];
    end else if (out_ready_in) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/sadc_frame_logic.sv
`timescale 1ns/1ps
`default_nettype none

module sadc_frame_logic
  import sadc_pkg::*;
(
  // Reference clock and reset
  input  wire logic                REF_CLK_IN,
  input  wire logic                ARST_N_IN,
  // Serial link from the host
  input  wire logic                SCLK_IN,
  input  wire logic                CS_N_IN,
  output logic                     SDO_OUT,
  output logic                     SDO_OE_OUT,
  // Levels at the two inputs, as unsigned fractions of the reference
  input  wire logic [RES_BITS-1:0] POSITIVE_ANALOG_INPUT_IN,
  input  wire logic [RES_BITS-1:0] NEGATIVE_ANALOG_INPUT_IN,
  // Status
  output logic [1:0]               STATE_OUT,
  output logic                     CAL_DONE_OUT
);

  // Link side, clocked by the serial clock
  logic                link_rst_n;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    cnt_d;
  logic [RES_BITS-1:0] word_q;
  logic                first_q;
  logic                powered_q;
  logic                done_tgl_q;
  logic                cal_tgl_q;
  logic                done_hit;
  logic                cal_hit;
  logic                sdo_q;
  logic                sdo_d;
  logic                bit_slot;
  logic [3:0]          bit_idx;

  // Reference side
  logic [2*RES_BITS+2:0] meta_q;
  logic [2*RES_BITS+2:0] sync_q;
  logic                  done_s;
  logic                  cal_s;
  logic                  cs_n_s;
  logic [RES_BITS-1:0]   pos_s;
  logic [RES_BITS-1:0]   neg_s;
  logic                  done_prev_q;
  logic                  cal_prev_q;
  logic                  cs_prev_q;
  logic                  done_evt;
  logic                  cal_evt;
  logic                  cs_fall;
  logic                  cs_rise;
  sadc_state_type        state_q;
  sadc_state_type        state_d;
  logic [RES_BITS-1:0]   hold_pos_q;
  logic [RES_BITS-1:0]   hold_neg_q;
  logic [CAL_CNT_W-1:0]  cal_cnt_q;
  logic                  cal_done_q;
  logic                  conv_ok;
  logic                  conv_short;
  logic                  cal_end;
  logic                  push_valid_q;
  logic [RES_BITS-1:0]   push_data_q;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [RES_BITS-1:0]   fifo_out_data;
  logic                  fifo_out_ready;
  logic                  fresh_q;
  logic [RES_BITS-1:0]   out_word_q;

  // Link logic. Chip select high holds it in reset, so a frame ends
  // without needing a serial clock edge after it.
  assign link_rst_n = ARST_N_IN && !CS_N_IN;

  assign cnt_d = (cnt_q == FALLS_RUN_CAL) ? cnt_q : cnt_q + FIRST_BIT_FALL;

  assign done_hit = (cnt_q == FALLS_TO_CONVERT - FIRST_BIT_FALL);
  assign cal_hit  = first_q ? (cnt_q == FALLS_FIRST_CAL - FIRST_BIT_FALL)
                            : (cnt_q == FALLS_RUN_CAL - FIRST_BIT_FALL);

  // Falling edges count the conversion steps
  always_ff @(negedge SCLK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Word is quasi-static: the reference side only changes it between frames
  always_ff @(negedge SCLK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      word_q  <= '0;
      first_q <= 1'b0;
    end else if (cnt_q == '0) begin
      word_q  <= out_word_q;
      first_q <= !powered_q;
    end
  end

  // Survive chip select: only the power-on reset clears these
  always_ff @(negedge SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      powered_q  <= 1'b0;
      done_tgl_q <= 1'b0;
      cal_tgl_q  <= 1'b0;
    end else begin
      powered_q  <= 1'b1;
      done_tgl_q <= done_tgl_q ^ (done_hit && link_rst_n);
      cal_tgl_q  <= cal_tgl_q ^ (cal_hit && link_rst_n);
    end
  end

  // Rising edges launch bits; the reset value is the leading zero
  assign bit_slot = (cnt_q >= FIRST_BIT_FALL) && (cnt_q <= LAST_BIT_FALL);
  assign bit_idx  = 4'(LAST_BIT_FALL - cnt_q);
  assign sdo_d    = bit_slot ? word_q[bit_idx] : 1'b0;

  always_ff @(posedge SCLK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  assign SDO_OUT    = sdo_q;
  assign SDO_OE_OUT = link_rst_n;

  // Reference side: synchronisers, sample hold, state, result queue
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      // Idle levels, so no false chip select or calibration edge follows reset
      meta_q <= {3'h1, {(2*RES_BITS){1'b0}}};
      sync_q <= {3'h1, {(2*RES_BITS){1'b0}}};
    end else begin
      meta_q <= {done_tgl_q, cal_tgl_q, CS_N_IN,
                 POSITIVE_ANALOG_INPUT_IN, NEGATIVE_ANALOG_INPUT_IN};
      sync_q <= meta_q;
    end
  end

  assign {done_s, cal_s, cs_n_s, pos_s, neg_s} = sync_q;

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      done_prev_q <= 1'b0;
      cal_prev_q  <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      done_prev_q <= done_s;
      cal_prev_q  <= cal_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  assign done_evt = done_s ^ done_prev_q;
  assign cal_evt  = cal_s ^ cal_prev_q;
  assign cs_fall  = cs_prev_q && !cs_n_s;
  assign cs_rise  = !cs_prev_q && cs_n_s;

  // Track while acquiring; the frame start freezes the sample
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      hold_pos_q <= '0;
      hold_neg_q <= '0;
    end else if (state_q == acquire_state && !cs_fall) begin
      hold_pos_q <= pos_s;
      hold_neg_q <= neg_s;
    end
  end

  // A pending result that the queue refuses stalls the conversion state
  assign conv_ok    = done_evt && !push_valid_q;
  assign conv_short = cs_rise && !done_evt && !push_valid_q;
  assign cal_end    = (cal_cnt_q == CAL_LAST);

  always_comb begin
    state_d = state_q;
    case (state_q)
      acquire_state: begin
        if (cal_evt) begin
          state_d = offset_cal_state;
        end else if (cs_fall) begin
          state_d = convert_state;
        end
      end
      convert_state: begin
        if (conv_ok || conv_short) begin
          state_d = acquire_state;
        end
      end
      offset_cal_state: begin
        if (cal_end) begin
          state_d = acquire_state;
        end
      end
      default: begin
        state_d = acquire_state;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= acquire_state;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cal_cnt_q  <= '0;
      cal_done_q <= 1'b0;
    end else if (state_q == offset_cal_state) begin
      cal_cnt_q  <= cal_cnt_q + 1'b1;
      cal_done_q <= cal_done_q || cal_end;
    end else begin
      cal_cnt_q  <= '0;
    end
  end

  // Result queued once per frame; a short frame queues the invalid code
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      push_valid_q <= 1'b0;
      push_data_q  <= '0;
    end else if (state_q == convert_state && conv_ok) begin
      push_valid_q <= 1'b1;
      push_data_q  <= to_code(hold_pos_q, hold_neg_q);
    end else if (state_q == convert_state && conv_short) begin
      push_valid_q <= 1'b1;
      push_data_q  <= INVALID_CODE;
    end else if (fifo_in_ready) begin
      push_valid_q <= 1'b0;
    end
  end

  sadc_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (REF_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .in_valid_in   (push_valid_q),
    .in_data_in    (push_data_q),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_out_ready)
  );

  // One word per idle gap, so each frame shows the previous frame's result
  assign fifo_out_ready = cs_n_s && !fresh_q;

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      fresh_q    <= 1'b0;
      out_word_q <= mid_scale_code;
    end else if (cs_fall) begin
      fresh_q    <= 1'b0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      fresh_q    <= 1'b1;
      out_word_q <= fifo_out_data;
    end
  end

  assign STATE_OUT    = state_q;
  assign CAL_DONE_OUT = cal_done_q;

  // Checks
  chk_idle_undriven: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    CS_N_IN |-> (!SDO_OE_OUT && !SDO_OUT))
    else $error("data pin driven while chip select high");

  chk_reset_acquire: assert property (
    @(posedge REF_CLK_IN)
    $rose(ARST_N_IN) |-> (state_q == acquire_state) && !cal_done_q)
    else $error("not in acquisition after reset");

  chk_frame_start: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state_q == acquire_state && cs_fall && !cal_evt) |=> (state_q == convert_state))
    else $error("frame start did not begin conversion");

  chk_sample_frozen: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state_q == convert_state) |=> $stable(hold_pos_q) && $stable(hold_neg_q))
    else $error("held sample moved during conversion");

  chk_code_extremes: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state_q == convert_state && conv_ok && hold_pos_q == FULL_INPUT
     && hold_neg_q == ZERO_INPUT) |=> (push_data_q == positive_full_scale_code))
    else $error("positive full scale code wrong");

  chk_code_sign: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state_q == convert_state && conv_ok && hold_pos_q < hold_neg_q)
    |=> push_data_q[RES_BITS-1] && push_valid_q)
    else $error("negative difference gave non-negative code");

  chk_short_invalid: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state_q == convert_state && conv_short)
    |=> (push_data_q == INVALID_CODE) && (state_q == acquire_state))
    else $error("short frame did not queue invalid result");

  chk_cal_entry: assert property (
    @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state_q == acquire_state && cal_evt) |=> (state_q == offset_cal_state))
    else $error("calibration request not taken");

  chk_lead_zero: assert property (
    @(negedge SCLK_IN) disable iff (!link_rst_n)
    (cnt_q == '0) |-> !sdo_q)
    else $error("no leading zero before first fall");

  chk_msb_launch: assert property (
    @(posedge SCLK_IN) disable iff (!link_rst_n)
    (cnt_q == FIRST_BIT_FALL) |=> (sdo_q == word_q[RES_BITS-1]))
    else $error("MSB not launched after first fall");

  chk_tail_zeros: assert property (
    @(posedge SCLK_IN) disable iff (!link_rst_n)
    (cnt_q > LAST_BIT_FALL) |=> !sdo_q)
    else $error("data pin not zero after result bits");

  chk_done_fifteen: assert property (
    @(negedge SCLK_IN) disable iff (!link_rst_n)
    (cnt_q == FALLS_TO_CONVERT - FIRST_BIT_FALL) |=> $changed(done_tgl_q))
    else $error("conversion end not flagged on fifteenth fall");

endmodule

`default_nettype wire

// >>> sim/sadc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sadc_host_model (
  // Frame request from the bench
  input  wire logic       req_in,
  input  wire logic [6:0] falls_in,
  output logic            done_out,
  // Serial link
  output logic            sclk_out,
  output logic            cs_n_out,
  input  wire logic       sdo_in,
  // Captured frame
  output logic [11:0]     word_out,
  output logic            tail_out
);
  logic v;

  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    done_out = 1'b0;
    word_out = 12'h000;
    tail_out = 1'b0;
    forever begin
      wait (req_in === 1'b1);
      #7 cs_n_out = 1'b0;
      tail_out = 1'b0;
      #20;
      // Clock only runs inside the frame, idles high
      for (int i = 1; i <= int'(falls_in); i++) begin
        v = sdo_in;
        sclk_out = 1'b0;
        if (i >= 2 && i <= 13) word_out = {word_out[10:0], v};
        else tail_out = tail_out | (v !== 1'b0);
        #32 sclk_out = 1'b1;
        #32;
      end
      cs_n_out = 1'b1;
      // Long idle gap so the next word is loaded before the next frame
      #1000 done_out = 1'b1;
      wait (req_in === 1'b0);
      done_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/test_serial_sar_adc_frame_logic.sv
`timescale 1ns/1ps
`default_nettype none

module test_serial_sar_adc_frame_logic;
  import sadc_pkg::*;

  logic             ref_clk, arst_n, req, sclk, cs_n, sdo, sdo_oe, done, tail, cal_done;
  logic [6:0]       falls;
  logic [11:0]      pos, neg, word;
  logic [1:0]       state;
  wire logic        sdo_line;
  int               fail_count, check_count, cycles;
  // Last entry is a mid-range pair, checked on the eighth frame of t_codes
  logic [11:0]      tp [7] = '{12'hfff, 12'h000, 12'h123, 12'h002, 12'h000, 12'h000, 12'h555};
  logic [11:0]      tn [7] = '{12'h000, 12'hfff, 12'h123, 12'h000, 12'hffe, 12'h004, 12'h123};
  logic [11:0]      te [7] = '{positive_full_scale_code, negative_full_scale_code,
                               mid_scale_code, 12'h001, 12'h801, 12'hffe, 12'h219};

  assign sdo_line = sdo_oe ? sdo : 1'bz;

  sadc_frame_logic sadc_frame_logic_inst (
    .REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
    .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .POSITIVE_ANALOG_INPUT_IN(pos),
    .NEGATIVE_ANALOG_INPUT_IN(neg), .STATE_OUT(state), .CAL_DONE_OUT(cal_done));

  sadc_host_model sadc_host_model_inst (
    .req_in(req), .falls_in(falls), .done_out(done), .sclk_out(sclk), .cs_n_out(cs_n),
    .sdo_in(sdo_line), .word_out(word), .tail_out(tail));

  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      $display("CHECK FAILED run length expected below 10000 seen %0d", cycles);
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset state", {10'h000, state}, 12'h000);
    check("reset cal done", {11'h000, cal_done}, 12'h000);
    check("reset data pin", {11'h000, sdo_line}, {11'h000, 1'bz});
    @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // One frame; next inputs are applied once conversion has begun, or after the frame ends if no conversion state was seen
  task automatic run_frame(input int nclk, input logic [11:0] np, input logic [11:0] nn,
                           output logic [11:0] w, output logic t, output logic conv,
                           output logic cal);
    int n;
    logic moved;
    n = 0;
    moved = 1'b0;
    conv = 1'b0;
    cal = 1'b0;
    falls <= 7'(nclk);
    req <= 1'b1;
    while (done !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
      conv = conv | (state === 2'b01);
      cal = cal | (state === 2'b11);
      @(posedge ref_clk);
      if (conv && !moved) begin
        pos <= np;
        neg <= nn;
        moved = 1'b1;
      end
    end
    check("frame finished", {11'h000, done}, 12'h001);
    if (!moved) begin
      pos <= np;
      neg <= nn;
    end
    w = word;
    t = tail;
    req <= 1'b0;
    repeat (30) begin
      @(negedge ref_clk);
      cal = cal | (state === 2'b11);
    end
    check("idle state", {10'h000, state}, 12'h000);
    check("idle data pin", {11'h000, sdo_line}, {11'h000, 1'bz});
    @(posedge ref_clk);
  endtask

  task automatic t_first_abort();
    logic [11:0] w;
    logic t, c, k;
    do_reset();
    run_frame(20, tp[0], tn[0], w, t, c, k);
    check("aborted first calibration", {11'h000, k}, 12'h000);
    check("cal done after abort", {11'h000, cal_done}, 12'h000);
  endtask

  task automatic t_first_cal();
    logic [11:0] w;
    logic t, c, k;
    do_reset();
    run_frame(24, tp[0], tn[0], w, t, c, k);
    check("first frame word", w, 12'h000);
    check("first frame tail", {11'h000, t}, 12'h000);
    check("first calibration", {11'h000, k}, 12'h001);
    check("cal done", {11'h000, cal_done}, 12'h001);
  endtask

  task automatic t_codes();
    logic [11:0] w;
    logic t, c, k;
    for (int i = 0; i < 8; i++) begin
      run_frame(16, tp[(i + 1) % 7], tn[(i + 1) % 7], w, t, c, k);
      check("conversion state", {11'h000, c}, 12'h001);
      check("frame tail", {11'h000, t}, 12'h000);
      if (i > 0) check("result code", w, te[i - 1]);
    end
  endtask

  task automatic t_short();
    logic [11:0] w;
    logic t, c, k;
    run_frame(10, 12'h100, 12'h000, w, t, c, k);
    run_frame(16, 12'h7ff, 12'h000, w, t, c, k);
    check("after short frame", w, INVALID_CODE);
    run_frame(16, 12'h000, 12'h000, w, t, c, k);
    check("recovered code", w, 12'h080);
  endtask

  task automatic t_run_cal();
    logic [11:0] w;
    logic t, c, k;
    run_frame(64, 12'h000, 12'h000, w, t, c, k);
    check("long frame word", w, 12'h3ff);
    check("long frame tail", {11'h000, t}, 12'h000);
    check("running calibration", {11'h000, k}, 12'h001);
    run_frame(40, 12'h000, 12'h000, w, t, c, k);
    check("aborted calibration", {11'h000, k}, 12'h000);
    run_frame(16, 12'h000, 12'h000, w, t, c, k);
    check("code after abort", w, mid_scale_code);
  endtask

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    req = 1'b0;
    falls = 7'h00;
    pos = 12'h000;
    neg = 12'h000;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    t_first_abort();
    t_first_cal();
    t_codes();
    t_short();
    t_run_cal();
    end_of_test();
  end
endmodule
`default_nettype wire
